// File: fpec_cfg.svh
// Purpose: Constants for the flash program/erase controller
// Assumes: APB byte addresses, 32-bit data words
// Notes: Register layout and timing counts live here
`ifndef FPEC_CFG_SVH
`define FPEC_CFG_SVH
// Register byte offsets
`define FPEC_MODE_OFS 12'h000
`define FPEC_TIMING_OFS 12'h004
`define FPEC_STATUS_OFS 12'h008
`define FPEC_IE_OFS 12'h00c
`define FPEC_IFG_OFS 12'h010
`define FPEC_ADDR_OFS 12'h014
`define FPEC_DATA_OFS 12'h018
`define FPEC_FUSE_OFS 12'h01c
// Key byte for the mode register
`define FPEC_KEY 8'ha5
// Byte shown in the key field when the mode or timing register is read
`define FPEC_KEY_READ 8'h96
// Mode register fields
`define FPEC_MODE_ERASE 1
`define FPEC_MODE_MERAS 2
`define FPEC_MODE_PROG 6
`define FPEC_MODE_SEGP 7
// Status register fields
`define FPEC_ST_BUSY 0
`define FPEC_ST_KEY_VIOLATION_FLAG 1
`define FPEC_ST_ACCV 2
`define FPEC_ST_WAIT 3
`define FPEC_ST_LOCK 4
// Interrupt enable / flag fields
`define FPEC_IRQ_OSC 1
`define FPEC_IRQ_PIN 4
`define FPEC_IRQ_ACCV 5
// Segment sizes in bytes
`define FPEC_MAIN_SEG_BYTES 512
`define FPEC_INFO_SEG_BYTES 128
// Operation lengths in timing-generator ticks
`define FPEC_PROG_TICKS 16'd35
`define FPEC_SEG_ERASE_TICKS 16'd4819
`define FPEC_MASS_ERASE_TICKS 16'd5297
// Timing register reset value
`define FPEC_TIMING_RST 8'h42
// Instruction word fed to a stalled fetch: jump to self
`define FPEC_JMP_SELF 16'h3fff
`endif

// File: fpec_cpu_model.sv
// Purpose: CPU side: APB master, flash fetches, timing sources
// Assumes: All changes just after rising pclk
// Notes: Waits for pready; only the bench timeout ends a wait
`timescale 1ns/1ps
module fpec_cpu_model (
  input wire logic pclk,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output fpec_pkg::fpec_fetch_type fetch,
  output logic [2:0] clk_src_lvl
);
  logic [1:0] ph;
  // Idle values at time zero
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    fetch = '0;
    ph = 2'h0;
  end
  // Free-running sources, never changed mid-operation
  always @(posedge pclk) ph <= ph + 2'h1;
  assign clk_src_lvl = {ph[0], ph[1], ph[0]};
  // One APB transfer, held until pready
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pready !== 1'b1 || pslverr !== 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask
  // Start or stop fetching from flash
  task automatic set_fetch(input logic rq, input logic [15:0] a);
    @(posedge pclk);
    fetch <= {rq, a};
  endtask
endmodule

// File: fpec_pkg.sv
// Purpose: Types for the flash program/erase controller
// Assumes: Constants come from fpec_cfg.svh
// Notes: No numbers are held here
package fpec_pkg;
  typedef enum logic [2:0] {
    FPEC_OP_NONE, FPEC_OP_PROG, FPEC_OP_SEG_ERASE, FPEC_OP_MASS_MAIN, FPEC_OP_MASS_ALL
  } fpec_op_type;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } fpec_cmd_type;
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } fpec_fetch_type;
endpackage

// File: fpec_timing_gen.sv
// Purpose: Divided tick source and operation timer
// Assumes: Clock sources arrive as levels synchronous to pclk
// Notes: One tick per divided source edge
`timescale 1ns/1ps
`include "fpec_cfg.svh"
module fpec_timing_gen #(
  parameter int DIV_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] src_sel_onehot,
  input wire logic [2:0] src_lvl,
  input wire logic [DIV_W-1:0] div,
  input wire logic start,
  input wire logic [15:0] ticks,
  output logic busy,
  output logic done
);
  logic src_q_r;
  logic src_now;
  logic src_edge;
  logic [DIV_W-1:0] pre_r;
  logic [15:0] cnt_r;
  logic tick;
  // Pick one of the three sources
  assign src_now = |(src_sel_onehot & src_lvl);
  assign src_edge = src_now & ~src_q_r;
  assign tick = src_edge && (pre_r == div);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q_r <= 1'b0;
    end else begin
      src_q_r <= src_now;
    end
  end
  // Division prescaler, factor div+1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (start || tick) begin
      pre_r <= '0;
    end else if (src_edge) begin
      pre_r <= pre_r + 1'b1;
    end
  end
  // Operation timer, all durations from the divided clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= ticks;
        busy <= 1'b1;
      end else if (busy && tick) begin
        if (cnt_r <= 16'd1) begin
          busy <= 1'b0;
          done <= 1'b1;
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_r - 16'd1;
        end
      end
    end
  end
endmodule

// File: fpec_top.sv
// Purpose: Flash program/erase controller with APB registers
// Assumes: CPU fetches and boundary-scan requests are pclk-synchronous
// Notes: Array itself sits outside; this block drives its strobes
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "fpec_cfg.svh"
module fpec_top #(
  parameter int MAIN_SEGS = 8,
  parameter int DIV_W = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fpec_pkg::fpec_fetch_type fetch,
  output logic fetch_stall,
  output logic [15:0] fetch_word,
  input wire logic [2:0] clk_src_lvl,
  input wire logic reset_pin_event,
  input wire logic osc_fault_event,
  input wire logic scan_req,
  output logic scan_grant,
  output logic nmi_req,
  output logic puc_req,
  output logic busy_out,
  output fpec_pkg::fpec_op_type array_op,
  output fpec_pkg::fpec_cmd_type array_cmd,
  output logic array_info_sel
);
  localparam logic [15:0] MAIN_BASE = 16'(32'h0001_0000 - MAIN_SEGS * `FPEC_MAIN_SEG_BYTES);
  localparam logic [15:0] INFO_BASE = 16'h1000;
  localparam logic [15:0] INFO_END = INFO_BASE + 16'(2 * `FPEC_INFO_SEG_BYTES);
  logic [7:0] mode_r;
  logic [7:0] timing_r;
  logic key_viol_r, acc_viol_r, wait_r, lock_r;
  logic [7:0] ie_r, ifg_r;
  logic [15:0] addr_r;
  logic [7:0] data_r;
  logic fuse_r;
  logic puc_r;
  logic soft_rst_n;
  logic wr, mode_wr, key_ok, op_busy, op_done, start;
  logic seg_sess_r, ctl_busy, mode_ok, acc_hit;
  logic [15:0] ticks;
  fpec_pkg::fpec_op_type op_nxt;
  logic in_main, in_info;
  logic [2:0] src_onehot;
  // APB strobes; zero-wait slave
  assign wr = psel & penable & pwrite;
  assign mode_wr = wr && paddr == `FPEC_MODE_OFS;
  assign key_ok = pwdata[15:8] == `FPEC_KEY;
  // Session busy covers the gaps between segment-write bytes
  assign ctl_busy = op_busy || seg_sess_r;
  // Mode write lands when idle or when a segment write waits
  assign mode_ok = mode_wr && key_ok && (!ctl_busy || (seg_sess_r && wait_r));
  // Keyed mode write mid-operation, or a fetch from a busy array
  assign acc_hit = (mode_wr && key_ok && !mode_ok) || (fetch.req && op_busy);
  // Power-up-clear joins external reset and key failure
  assign soft_rst_n = presetn & ~puc_r;
  // Address windows of the array
  assign in_info = addr_r >= INFO_BASE && addr_r < INFO_END;
  assign in_main = addr_r >= MAIN_BASE;
  // Clear pulse when a mode register write has the wrong key byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      puc_r <= 1'b0;
    end else begin
      puc_r <= mode_wr && !key_ok && !puc_r;
    end
  end
  // Operation and tick count decode from mode bits alone
  always_comb begin
    op_nxt = fpec_pkg::FPEC_OP_NONE;
    ticks = `FPEC_PROG_TICKS;
    if (mode_r[`FPEC_MODE_MERAS] && mode_r[`FPEC_MODE_ERASE]) begin
      op_nxt = fpec_pkg::FPEC_OP_MASS_ALL;
      ticks = `FPEC_MASS_ERASE_TICKS;
    end else if (mode_r[`FPEC_MODE_MERAS]) begin
      op_nxt = fpec_pkg::FPEC_OP_MASS_MAIN;
      ticks = `FPEC_MASS_ERASE_TICKS;
    end else if (mode_r[`FPEC_MODE_ERASE]) begin
      op_nxt = fpec_pkg::FPEC_OP_SEG_ERASE;
      ticks = `FPEC_SEG_ERASE_TICKS;
    end else if (mode_r[`FPEC_MODE_PROG] || mode_r[`FPEC_MODE_SEGP]) begin
      op_nxt = fpec_pkg::FPEC_OP_PROG;
    end
  end
  // Writing the data register launches the selected operation
  assign start = wr && paddr == `FPEC_DATA_OFS && !op_busy && !lock_r && op_nxt != fpec_pkg::FPEC_OP_NONE
    && (in_main || in_info);
  // One-hot source select from timing bits 7:6; code 3 falls back to the third
  always_comb begin
    unique case (timing_r[7:6])
      2'd0: src_onehot = 3'b001;
      2'd1: src_onehot = 3'b010;
      default: src_onehot = 3'b100;
    endcase
  end
  fpec_timing_gen #(
    .DIV_W(DIV_W)
  ) u_tgen (
    .pclk(pclk),
    .presetn(soft_rst_n),
    .src_sel_onehot(src_onehot),
    .src_lvl(clk_src_lvl),
    .div(timing_r[DIV_W-1:0]),
    .start(start),
    .ticks(ticks),
    .busy(op_busy),
    .done(op_done)
  );
  // Mode register with key and busy guard
  always_ff @(posedge pclk or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      mode_r <= 8'h00;
    end else if (mode_ok) begin
      mode_r <= pwdata[7:0];
    end else if (op_done && !mode_r[`FPEC_MODE_SEGP]) begin
      mode_r[`FPEC_MODE_ERASE] <= 1'b0;
      mode_r[`FPEC_MODE_MERAS] <= 1'b0;
    end
  end
  // Timing register
  always_ff @(posedge pclk or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      timing_r <= `FPEC_TIMING_RST;
    end else if (wr && paddr == `FPEC_TIMING_OFS && pwdata[15:8] == `FPEC_KEY && !op_busy) begin
      timing_r <= pwdata[7:0];
    end
  end
  // Status: lock writable anytime; wait cleared by start, set by done
  always_ff @(posedge pclk or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      lock_r <= 1'b0;
      wait_r <= 1'b1;
    end else begin
      if (wr && paddr == `FPEC_STATUS_OFS) begin
        lock_r <= pwdata[`FPEC_ST_LOCK];
      end
      if (start) begin
        wait_r <= 1'b0;
      end else if (op_done) begin
        wait_r <= 1'b1;
      end
    end
  end
  // Segment-write session: from first byte until mode leaves segment write
  always_ff @(posedge pclk or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      seg_sess_r <= 1'b0;
    end else if (start && mode_r[`FPEC_MODE_SEGP]) begin
      seg_sess_r <= 1'b1;
    end else if (mode_ok && !pwdata[`FPEC_MODE_SEGP]) begin
      seg_sess_r <= 1'b0;
    end
  end
  // Violation flag, set beats clear
  always_ff @(posedge pclk or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      acc_viol_r <= 1'b0;
    end else if (acc_hit) begin
      acc_viol_r <= 1'b1;
    end else if (wr && paddr == `FPEC_STATUS_OFS) begin
      acc_viol_r <= pwdata[`FPEC_ST_ACCV];
    end
  end
  // Key flag survives clear; power-on only
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      key_viol_r <= 1'b0;
    end else if (mode_wr && !key_ok) begin
      key_viol_r <= 1'b1;
    end else if (wr && paddr == `FPEC_STATUS_OFS) begin
      key_viol_r <= pwdata[`FPEC_ST_KEY_VIOLATION_FLAG];
    end
  end
  // Shared interrupt enables and sticky flags
  always_ff @(posedge pclk or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      ie_r <= 8'h00;
      ifg_r <= 8'h00;
    end else begin
      if (wr && paddr == `FPEC_IE_OFS) begin
        ie_r <= pwdata[7:0];
      end
      if (wr && paddr == `FPEC_IFG_OFS) begin
        ifg_r <= pwdata[7:0];
      end
      if (reset_pin_event) begin
        ifg_r[`FPEC_IRQ_PIN] <= 1'b1;
      end
      if (osc_fault_event) begin
        ifg_r[`FPEC_IRQ_OSC] <= 1'b1;
      end
      if (acc_hit) begin
        ifg_r[`FPEC_IRQ_ACCV] <= 1'b1;
      end
    end
  end
  // Target address register
  always_ff @(posedge pclk or negedge soft_rst_n) begin
    if (!soft_rst_n) begin
      addr_r <= 16'h0000;
      data_r <= 8'h00;
    end else begin
      if (wr && paddr == `FPEC_ADDR_OFS && !op_busy) begin
        addr_r <= pwdata[15:0];
      end
      if (start) begin
        data_r <= pwdata[7:0];
      end
    end
  end
  // Fuse: once blown, never clears except power-on
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      fuse_r <= 1'b0;
    end else if (wr && paddr == `FPEC_FUSE_OFS && pwdata[7:0] == `FPEC_KEY) begin
      fuse_r <= 1'b1;
    end
  end
  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      fetch_stall <= 1'b0;
      fetch_word <= 16'h0000;
      scan_grant <= 1'b0;
      nmi_req <= 1'b0;
      puc_req <= 1'b0;
      busy_out <= 1'b0;
      array_op <= fpec_pkg::FPEC_OP_NONE;
      array_cmd <= '0;
      array_info_sel <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          `FPEC_MODE_OFS: prdata <= {16'h0000, `FPEC_KEY_READ, mode_r};
          `FPEC_TIMING_OFS: prdata <= {16'h0000, `FPEC_KEY_READ, timing_r};
          `FPEC_STATUS_OFS: prdata <= {27'h0, lock_r, wait_r, acc_viol_r, key_viol_r, ctl_busy};
          `FPEC_IE_OFS: prdata <= {24'h0, ie_r};
          `FPEC_IFG_OFS: prdata <= {24'h0, ifg_r};
          `FPEC_ADDR_OFS: prdata <= {16'h0, addr_r};
          `FPEC_DATA_OFS: prdata <= {24'h0, data_r};
          `FPEC_FUSE_OFS: prdata <= {31'h0, fuse_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (psel && !penable && !(paddr inside {`FPEC_MODE_OFS, `FPEC_TIMING_OFS, `FPEC_STATUS_OFS, `FPEC_IE_OFS,
          `FPEC_IFG_OFS, `FPEC_ADDR_OFS, `FPEC_DATA_OFS, `FPEC_FUSE_OFS})) begin
        pslverr <= 1'b1;
      end
      // Busy fetches see the jump-to-self word
      fetch_stall <= fetch.req && op_busy;
      fetch_word <= `FPEC_JMP_SELF;
      scan_grant <= scan_req && !fuse_r;
      // Shared request from any enabled source flag
      nmi_req <= |(ie_r & ifg_r & 8'h32);
      puc_req <= puc_r;
      busy_out <= op_busy || start;
      array_op <= start ? op_nxt : (op_busy ? array_op : fpec_pkg::FPEC_OP_NONE);
      if (start) begin
        array_cmd <= '{addr: addr_r, data: pwdata[7:0]};
        array_info_sel <= in_info;
      end
    end
  end
endmodule

// File: fpec_top_assertions.sv
// Purpose: Port checks for the flash program/erase controller
// Assumes: One pclk domain, presetn async active low
// Notes: Bound to every fpec_top below
`timescale 1ns/1ps
`include "fpec_cfg.svh"
module fpec_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire fpec_pkg::fpec_fetch_type fetch,
  input wire logic fetch_stall,
  input wire logic [15:0] fetch_word,
  input wire logic scan_req,
  input wire logic scan_grant,
  input wire logic puc_req,
  input wire logic busy_out,
  input wire fpec_pkg::fpec_op_type array_op
);
  // Shared clock and reset
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed writes
  wire logic w_done = psel && penable && pready && pwrite;
  wire logic w_start = w_done && paddr == `FPEC_DATA_OFS;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_when_idle: assert property (!psel |=> !pready)
    else $error("ready without select");
  a_stall_word: assert property (fetch_stall |-> fetch_word == `FPEC_JMP_SELF)
    else $error("wrong stall word");
  a_stall_on_busy: assert property (fetch.req && busy_out |=> fetch_stall || !busy_out)
    else $error("busy fetch not stalled");
  a_bad_key_clear: assert property (w_done && paddr == `FPEC_MODE_OFS && pwdata[15:8] != `FPEC_KEY |-> ##[1:2] puc_req)
    else $error("bad key without clear");
  a_busy_cause: assert property ($rose(busy_out) |-> $past(w_start) || $past(w_start, 2))
    else $error("busy without start");
  a_busy_min_len: assert property ($rose(busy_out) |-> busy_out [*8])
    else $error("busy too short");
  a_op_steady: assert property (busy_out && $past(busy_out) |-> $stable(array_op))
    else $error("operation changed while busy");
  a_grant_needs_req: assert property (scan_grant |-> $past(scan_req))
    else $error("grant without request");
  a_fuse_blocks_scan: assert property (w_done && paddr == `FPEC_FUSE_OFS && pwdata[7:0] == 8'ha5 |-> ##2 !scan_grant [*8])
    else $error("scan granted after fuse");
endmodule
bind fpec_top fpec_checker chk_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .fetch,
  .fetch_stall, .fetch_word, .scan_req, .scan_grant, .puc_req, .busy_out, .array_op);

// File: tb_flash_program_erase_control.sv
// Purpose: Self-checking bench for the flash program/erase controller
// Assumes: CPU model supplies bus cycles and timing sources
// Notes: Erase runs make this about 50k cycles long
`timescale 1ns/1ps
`include "fpec_cfg.svh"
module tb_flash_program_erase_control;
  logic pclk, presetn, por_n, pready, pslverr, psel, penable, pwrite, e;
  logic fetch_stall, scan_req, scan_grant, nmi_req, puc_req, busy_out, array_info_sel;
  logic reset_pin_event, osc_fault_event;
  logic [11:0] paddr;
  logic [31:0] prdata, pwdata, r;
  logic [15:0] fetch_word;
  logic [2:0] clk_src_lvl;
  fpec_pkg::fpec_fetch_type fetch;
  fpec_pkg::fpec_op_type array_op;
  fpec_pkg::fpec_cmd_type array_cmd;
  int error_cnt, n_tests, cyc;
  fpec_top dut (.pclk, .presetn, .por_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .fetch, .fetch_stall, .fetch_word, .clk_src_lvl, .reset_pin_event, .osc_fault_event, .scan_req, .scan_grant,
    .nmi_req, .puc_req, .busy_out, .array_op, .array_cmd, .array_info_sel);
  fpec_cpu_model cpu (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .fetch,
    .clk_src_lvl);
  // 200 MHz clock
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    cpu.xfer(1'b0, a, 32'h0, r, e);
    chk("register", r & m, x);
    chk("bus error", e, 1'b0);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic do_reset(input logic por);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= ~por;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
  endtask
  // Set up, start, time and close one operation
  task automatic run_op(input logic [7:0] m, input logic [15:0] a, input logic [7:0] tm, input int cpt,
                        input int tk, input fpec_pkg::fpec_op_type eo, input logic ei, input logic v);
    int t0;
    wr(`FPEC_TIMING_OFS, {16'h0, `FPEC_KEY, tm});
    rd(`FPEC_TIMING_OFS, 32'hff, {24'h0, tm});
    wr(`FPEC_MODE_OFS, {16'h0, `FPEC_KEY, m});
    rd(`FPEC_MODE_OFS, 32'hff, {24'h0, m});
    wr(`FPEC_ADDR_OFS, {16'h0, a});
    wr(`FPEC_DATA_OFS, 32'h5a);
    t0 = cyc;
    settle();
    chk("op", array_op, eo);
    if (eo == fpec_pkg::FPEC_OP_SEG_ERASE) chk("info", array_info_sel, ei);
    if (v) begin
      rd(`FPEC_STATUS_OFS, 32'h1, 32'h1);
      wr(`FPEC_MODE_OFS, {16'h0, `FPEC_KEY, 8'h02});
      rd(`FPEC_STATUS_OFS, 32'h5, 32'h5);
      rd(`FPEC_MODE_OFS, 32'hff, {24'h0, m});
      cpu.set_fetch(1'b1, 16'hf010);
      settle();
      chk("stall", {fetch_stall, fetch_word}, {1'b1, `FPEC_JMP_SELF});
      cpu.set_fetch(1'b0, 16'hf010);
    end
    while (busy_out === 1'b1 && cyc - t0 < 30000) @(negedge pclk);
    chk("length", cyc - t0 >= cpt * (tk - 1) && cyc - t0 <= cpt * tk + 6, 1'b1);
    chk("cmd", array_cmd, {a, 8'h5a});
    rd(`FPEC_STATUS_OFS, 32'h1, 32'h0);
  endtask
  // Main sequence; interrupt enables stay clear during operations
  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    scan_req = 1'b1;
    reset_pin_event = 1'b0;
    osc_fault_event = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    rd(`FPEC_MODE_OFS, 32'hffff, 32'h9600);
    rd(`FPEC_TIMING_OFS, 32'hff, 32'h42);
    rd(`FPEC_STATUS_OFS, 32'h0f, 32'h08);
    rd(`FPEC_IE_OFS, 32'h32, 32'h0);
    cpu.xfer(1'b0, 12'h040, 32'h0, r, e);
    chk("unmapped", e, 1'b1);
    run_op(8'h02, 16'h1080, 8'h00, 2, 4819, fpec_pkg::FPEC_OP_SEG_ERASE, 1'b1, 1'b0);
    run_op(8'h40, 16'hf100, 8'h40, 4, 35, fpec_pkg::FPEC_OP_PROG, 1'b0, 1'b1);
    wr(`FPEC_STATUS_OFS, 32'h08);
    rd(`FPEC_STATUS_OFS, 32'h04, 32'h0);
    run_op(8'h02, 16'hf200, 8'h01, 4, 4819, fpec_pkg::FPEC_OP_SEG_ERASE, 1'b0, 1'b0);
    run_op(8'h04, 16'hf000, 8'h00, 2, 5297, fpec_pkg::FPEC_OP_MASS_MAIN, 1'b0, 1'b0);
    run_op(8'h06, 16'hf000, 8'h00, 2, 5297, fpec_pkg::FPEC_OP_MASS_ALL, 1'b0, 1'b0);
    // Shared interrupt: flags, enables, clearing
    rd(`FPEC_IFG_OFS, 32'h32, 32'h20);
    chk("nmi", nmi_req, 1'b0);
    wr(`FPEC_IE_OFS, 32'h20);
    settle();
    chk("nmi", nmi_req, 1'b1);
    wr(`FPEC_IFG_OFS, 32'h0);
    settle();
    chk("nmi", nmi_req, 1'b0);
    @(posedge pclk);
    osc_fault_event <= 1'b1;
    reset_pin_event <= 1'b1;
    @(posedge pclk);
    osc_fault_event <= 1'b0;
    reset_pin_event <= 1'b0;
    rd(`FPEC_IFG_OFS, 32'h32, 32'h12);
    chk("nmi", nmi_req, 1'b0);
    wr(`FPEC_IE_OFS, 32'h10);
    settle();
    chk("nmi", nmi_req, 1'b1);
    wr(`FPEC_IE_OFS, 32'h0);
    // Segment write: busy holds between bytes, mode accepted while waiting
    wr(`FPEC_MODE_OFS, {16'h0, `FPEC_KEY, 8'h80});
    wr(`FPEC_ADDR_OFS, 32'hf300);
    wr(`FPEC_DATA_OFS, 32'h11);
    settle();
    while (busy_out === 1'b1) @(negedge pclk);
    rd(`FPEC_STATUS_OFS, 32'h0d, 32'h09);
    wr(`FPEC_MODE_OFS, {16'h0, `FPEC_KEY, 8'h00});
    rd(`FPEC_STATUS_OFS, 32'h0d, 32'h08);
    rd(`FPEC_MODE_OFS, 32'hff, 32'h0);
    // Fuse, bad key, then both resets
    chk("grant", scan_grant, 1'b1);
    wr(`FPEC_FUSE_OFS, 32'ha5);
    settle();
    chk("grant", scan_grant, 1'b0);
    wr(`FPEC_MODE_OFS, 32'h5a40);
    rd(`FPEC_STATUS_OFS, 32'h0f, 32'h0a);
    rd(`FPEC_TIMING_OFS, 32'hff, 32'h42);
    do_reset(1'b0);
    rd(`FPEC_STATUS_OFS, 32'h02, 32'h02);
    chk("grant", scan_grant, 1'b0);
    do_reset(1'b1);
    rd(`FPEC_STATUS_OFS, 32'h02, 32'h0);
    tally_and_finish();
  end
endmodule
